/* bench/ppabc_checker_sva.sv */
// Timing checks on the port A, B and C pins
`timescale 1ns/1ps
module ppabc_checker_sva (
  // Watched ports
  input wire        clk,
  input wire        reset,
  input wire [15:0] regAddr,
  input wire        regWr,
  input wire        regRd,
  input wire [1:0]  modeSel,
  input wire [7:3]  cmpCtl,
  input wire [7:3]  cmpVal,
  input wire        pulseCountInput,
  input wire [3:0]  captureIn,
  input wire [7:0]  pulseCountControl_r,
  input wire [7:0]  paIn,
  input wire [7:3]  paOut,
  input wire        paOeN7,
  input wire        paOeN3,
  input wire [7:0]  pbOut_r,
  input wire [7:0]  pcOut_r,
  input wire [7:0]  pcOeN_r,
  input wire [15:0] busAddr,
  input wire        busAddrPhase,
  input wire        pcExtAccess_r
);
  // --------
  // Checks
  // --------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Straps settle one edge after release, so hold off a few edges
  reg  [1:0] goCnt_r;
  wire       go = (goCnt_r == 2'h3);
  always @(posedge clk or posedge reset) begin
    if (reset) goCnt_r <= 2'h0;
    else if (!go) goCnt_r <= goCnt_r + 2'h1;
  end
  AST_PULSE_IN: assert property (go |=> pulseCountInput == $past(paIn[7]))
    else $error("pulse input not following pin 7");
  AST_CAPTURE: assert property (go |=> captureIn == $past(paIn[3:0]))
    else $error("capture inputs not following pins");
  AST_PA7_CMP: assert property (go && cmpCtl[7] |=> !paOeN7 && paOut[7] == $past(cmpVal[7]))
    else $error("pin 7 not owned by compare");
  AST_PA7_DIR: assert property (go && !cmpCtl[7] |=> paOeN7 == !$past(pulseCountControl_r[7]))
    else $error("pin 7 direction wrong");
  AST_PA3_CMP: assert property (go && cmpCtl[3] && pulseCountControl_r[2] |=> !paOeN3 && paOut[3] == $past(cmpVal[3]))
    else $error("pin 3 not owned by compare");
  AST_PB_ADDR: assert property (go && modeSel[1] |=> pbOut_r == $past(busAddr[15:8]))
    else $error("port B not showing high address");
  AST_PC_ADDR: assert property (go && modeSel[1] && busAddrPhase |=> pcOut_r == $past(busAddr[7:0]) && pcOeN_r == 8'h00)
    else $error("port C not showing low address");
  AST_PC_EXT: assert property (go && modeSel[1] && (regWr || regRd) && regAddr == 16'h1003 |=> pcExtAccess_r)
    else $error("port C access not sent out");
endmodule // ppabc_checker_sva

bind ppabc_top ppabc_checker_sva ppabc_checker_sva_i (.clk(clk), .reset(reset), .regAddr(regAddr),
  .regWr(regWr), .regRd(regRd), .modeSel(modeSel), .cmpCtl(cmpCtl), .cmpVal(cmpVal),
  .pulseCountInput(pulseCountInput), .captureIn(captureIn), .pulseCountControl_r(pulseCountControl_r),
  .paIn(paIn), .paOut(paOut), .paOeN7(paOeN7), .paOeN3(paOeN3), .pbOut_r(pbOut_r), .pcOut_r(pcOut_r),
  .pcOeN_r(pcOeN_r), .busAddr(busAddr), .busAddrPhase(busAddrPhase), .pcExtAccess_r(pcExtAccess_r));

/* bench/ppabc_pins_model.sv */
// Pin-level model of the board around ports A and C
`timescale 1ns/1ps
module ppabc_pins_model (
  // Port drivers
  input  wire [7:3] paOut,
  input  wire       paOeN7,
  input  wire       paOeN3,
  input  wire [7:0] pcOut,
  input  wire [7:0] pcOeN,
  // Far-side levels
  input  wire [7:0] extA,
  input  wire [7:0] extC,
  // Resolved pins
  output wire [7:0] paIn,
  output wire [7:0] pcIn
);
  // Driven pins read back their own level; released ones show the far side
  assign paIn = {paOeN7 ? extA[7] : paOut[7], paOut[6:4], paOeN3 ? extA[3] : paOut[3], extA[2:0]};
  assign pcIn = (pcOut & ~pcOeN) | (extC & pcOeN);
endmodule // ppabc_pins_model

/* bench/ppabc_tb_top.sv */
// Self-checking bench for ports A, B and C
`timescale 1ns/1ps
module ppabc_tb_top;
  // --------
  // Signals
  // --------
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [15:0] regAddr = 16'h0000;
  logic [7:0]  regWrData = 8'h00;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [1:0]  modeSel = 2'h1;
  logic [7:3]  cmpCtl = 5'h00;
  logic [7:3]  cmpVal = 5'h00;
  logic [15:0] busAddr = 16'h0000;
  logic [7:0]  busWrData = 8'h00;
  logic        busAddrPhase = 1'b0;
  logic        busWrPhase = 1'b0;
  logic [7:0]  extA = 8'h00;
  logic [7:0]  extC = 8'h00;
  logic        rdSeen = 1'b0;
  logic [7:0]  expQ[$];
  logic [7:0]  v, d, w;
  logic [4:0]  c;
  int          errors = 0;
  int          cmp_count = 0;
  wire  [7:0]  regRdData_r, pulseCountControl_r, paIn, pbOut_r, pcIn, pcOut_r, pcOeN_r, busRdData_r;
  wire  [7:3]  paOut;
  wire  [3:0]  captureIn;
  wire         pulseCountInput, paOeN7, paOeN3, pcExtAccess_r;

  always #12.5 clk = ~clk;

  ppabc_top ppabc_top_i (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData_r(regRdData_r), .modeSel(modeSel), .cmpCtl(cmpCtl),
    .cmpVal(cmpVal), .pulseCountInput(pulseCountInput), .captureIn(captureIn),
    .pulseCountControl_r(pulseCountControl_r), .paIn(paIn), .paOut(paOut), .paOeN7(paOeN7),
    .paOeN3(paOeN3), .pbOut_r(pbOut_r), .pcIn(pcIn), .pcOut_r(pcOut_r), .pcOeN_r(pcOeN_r),
    .busAddr(busAddr), .busWrData(busWrData), .busAddrPhase(busAddrPhase), .busWrPhase(busWrPhase),
    .busRdData_r(busRdData_r), .pcExtAccess_r(pcExtAccess_r));
  ppabc_pins_model ppabc_pins_model_i (.paOut(paOut), .paOeN7(paOeN7), .paOeN3(paOeN3),
    .pcOut(pcOut_r), .pcOeN(pcOeN_r), .extA(extA), .extC(extC), .paIn(paIn), .pcIn(pcIn));

  // --------
  // Tasks
  // --------
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(input logic [15:0] a, input logic [7:0] x);
    @(posedge clk);
    regAddr <= a;
    regWrData <= x;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    expQ.push_back(e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
  endtask
  task rst(input logic [1:0] m);
    @(posedge clk);
    modeSel <= m;
    reset <= 1'b1;
    extA <= 8'($urandom);
    extC <= 8'($urandom);
    wt(2);
    chk("paOut", 8'h00, {5'h0, paOut[6:4]});
    chk("paOeN", 8'h03, {6'h0, paOeN7, paOeN3});
    chk("pbOut_r", 8'h00, pbOut_r);
    chk("pcOeN_r", 8'hff, pcOeN_r);
    @(posedge clk);
    reset <= 1'b0;
    wt(2);
  endtask
  task summarize;
    $display("checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rdSeen <= regRd;
    if (rdSeen) chk("regRdData_r", expQ.pop_front(), regRdData_r);
  end

  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    summarize();
  end

  initial begin
    v = 8'($urandom(32'h23bc));
    for (int m = 0; m < 4; m++) begin
      {v, d, w, c} = 29'($urandom);
      rst(m[1:0]);
      if (m < 2) begin
        rd(16'h1007, 8'h00);
        rd(16'h1003, extC);
        wr(16'h1004, v);
        wr(16'h1007, d);
        wr(16'h1003, w);
        wr(16'h1001, 8'hff);
        wt(2);
        chk("pbOut_r", v, pbOut_r);
        chk("pcOeN_r", ~d, pcOeN_r);
        chk("pcOut_r", w & d, pcOut_r & d);
        rd(16'h1003, (w & d) | (extC & ~d));
        rd(16'h1001, 8'h00);
        wr(16'h1026, 8'h88);
        wr(16'h1000, w);
        wt(2);
        chk("paOut", {3'h0, w[7:3]}, {3'h0, paOut});
        chk("paOeN", 8'h00, {6'h0, paOeN7, paOeN3});
        chk("pulseCountInput", {7'h0, w[7]}, {7'h0, pulseCountInput});
        @(posedge clk);
        cmpCtl <= 5'h1f;
        cmpVal <= c;
        wt(2);
        chk("paOut", {3'h0, c[4:1], w[3]}, {3'h0, paOut});
        wr(16'h1026, 8'h04);
        wt(2);
        chk("paOut", {3'h0, c}, {3'h0, paOut});
        chk("paOeN", 8'h00, {6'h0, paOeN7, paOeN3});
        @(posedge clk);
        cmpCtl <= 5'h00;
        wt(2);
        chk("paOeN", 8'h03, {6'h0, paOeN7, paOeN3});
        chk("captureIn", {4'h0, extA[3:0]}, {4'h0, captureIn});
        rd(16'h1000, {extA[7], w[6:4], extA[3:0]});
        rd(16'h1026, 8'h04);
      end else begin
        @(posedge clk);
        busAddr <= {v, w};
        busWrData <= d;
        busAddrPhase <= 1'b1;
        wt(2);
        chk("pbOut_r", v, pbOut_r);
        chk("pcOut_r", w, pcOut_r);
        chk("pcOeN_r", 8'h00, pcOeN_r);
        @(posedge clk);
        busAddrPhase <= 1'b0;
        busWrPhase <= 1'b1;
        wt(2);
        chk("pcOut_r", d, pcOut_r);
        @(posedge clk);
        busWrPhase <= 1'b0;
        wt(2);
        chk("pcOeN_r", 8'hff, pcOeN_r);
        chk("busRdData_r", extC, busRdData_r);
        rd(16'h1004, v);
        rd(16'h1003, 8'h00);
        #1;
        chk("pcExtAccess_r", 8'h01, {7'h0, pcExtAccess_r});
      end
      $display("test %0d done", m);
    end
    wt(2);
    summarize();
  end
endmodule // ppabc_tb_top

/* verilog/ppabc_consts.vh */
// Constants shared by the port A, B and C logic
`ifndef PPABC_CONSTS_VH
`define PPABC_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PPABC_OFF_PA_DATA 16'h1000
`define PPABC_OFF_PC_DATA 16'h1003
`define PPABC_OFF_PB_DATA 16'h1004
`define PPABC_OFF_DIRC    16'h1007
`define PPABC_OFF_PCTL    16'h1026

// ----------------------------------------
// Pulse count control fields
// ----------------------------------------
`define PPABC_PCTL_DIR7   7
`define PPABC_PCTL_DIR3   3
`define PPABC_PCTL_CMP3   2

// ----------------------------------------
// Reset values and the strap-taken set bit
// ----------------------------------------
`define PPABC_RST_BYTE    8'h00
`define PPABC_RST_HIZ     8'hff
`define PPABC_RST_PA_OUT  5'h00
`define PPABC_RST_PA_HIZ  1'h1
`define PPABC_RST_BIT     1'h0
`define PPABC_RST_CAP     4'h0
`define PPABC_BIT_ON      1'h1

// ----------------------------------------
// Operating modes on the strap pins
// ----------------------------------------
`define PPABC_MODE_BOOT   2'h0
`define PPABC_MODE_SINGLE 2'h1
`define PPABC_MODE_TEST   2'h2
`define PPABC_MODE_EXPAND 2'h3

`endif

/* verilog/ppabc_port_a.v */
// Port A pin logic shared with the timer
`timescale 1ns/1ps
`include "ppabc_consts.vh"

module ppabc_port_a (
  // Clock and reset
  input  wire       clk,
  input  wire       reset,
  // Register side
  input  wire [7:0] wrData,
  input  wire       wrEn,
  input  wire       dir7,
  input  wire       dir3,
  input  wire       cmpOn3,
  // Timer side
  input  wire [7:3] cmpCtl,
  input  wire [7:3] cmpVal,
  // Pins
  input  wire [7:0] paIn,
  output reg  [7:3] paOut_r,
  output reg        paOeN7_r,
  output reg        paOeN3_r,
  output reg        pulseIn_r,
  output reg  [3:0] captureIn_r,
  output wire [7:0] readVal
);

  reg  [7:3] latch_r;
  // Bit 3 is a compare pin only when cmpOn3 also selects compare for it, not on the timer's cmpCtl[3] alone
  wire [7:3] timerOwns = {cmpCtl[7:4], cmpCtl[3] & cmpOn3};
  wire [7:3] driveNxt  = (timerOwns & cmpVal) | (~timerOwns & latch_r);
  wire       out7      = dir7 | timerOwns[7];
  wire       out3      = dir3 | timerOwns[3];

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      latch_r     <= `PPABC_RST_PA_OUT;
      paOut_r     <= `PPABC_RST_PA_OUT;
      paOeN7_r    <= `PPABC_RST_PA_HIZ;
      paOeN3_r    <= `PPABC_RST_PA_HIZ;
      pulseIn_r   <= `PPABC_RST_BIT;
      captureIn_r <= `PPABC_RST_CAP;
    end else begin
      if (wrEn) begin
        latch_r <= wrData[7:3];
      end
      paOut_r     <= driveNxt;
      paOeN7_r    <= ~out7;
      paOeN3_r    <= ~out3;
      pulseIn_r   <= paIn[7];
      captureIn_r <= paIn[3:0];
    end
  end

  // Outputs read back what is driven, inputs read the pin
  assign readVal = {out7 ? paOut_r[7] : paIn[7], paOut_r[6:4],
                    out3 ? paOut_r[3] : paIn[3], paIn[2:0]};

endmodule // ppabc_port_a

/* verilog/ppabc_port_c.v */
// Port C general-purpose data and direction bits
`timescale 1ns/1ps
`include "ppabc_consts.vh"

module ppabc_port_c (
  // Clock and reset
  input  wire       clk,
  input  wire       reset,
  // Register side
  input  wire [7:0] wrData,
  input  wire       dataWr,
  input  wire       dirWr,
  // Pins
  input  wire [7:0] pcIn,
  output wire [7:0] gpioOut,
  output wire [7:0] gpioOeN,
  output wire [7:0] readVal,
  output wire [7:0] dirBits
);

  reg [7:0] data_r;
  reg [7:0] dir_r;

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : gBit
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          data_r[i] <= `PPABC_RST_BIT;
          dir_r[i]  <= `PPABC_RST_BIT;
        end else begin
          if (dataWr) begin
            data_r[i] <= wrData[i];
          end
          if (dirWr) begin
            dir_r[i] <= wrData[i];
          end
        end
      end
      assign gpioOut[i] = data_r[i];
      assign gpioOeN[i] = ~dir_r[i];
      assign readVal[i] = dir_r[i] ? data_r[i] : pcIn[i];
    end
  endgenerate

  assign dirBits = dir_r;

endmodule // ppabc_port_c

/* verilog/ppabc_top.v */
// Parallel ports A, B and C with register port and bus-mode muxing
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "ppabc_consts.vh"

module ppabc_top (
  // Clock and reset
  input  wire        clk,
  input  wire        reset,
  // Register port
  input  wire [15:0] regAddr,
  input  wire [7:0]  regWrData,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [7:0]  regRdData_r,
  // Mode straps
  input  wire [1:0]  modeSel,
  // Timer
  input  wire [7:3]  cmpCtl,
  input  wire [7:3]  cmpVal,
  output wire        pulseCountInput,
  output wire [3:0]  captureIn,
  output reg  [7:0]  pulseCountControl_r,
  // Port A pins
  input  wire [7:0]  paIn,
  output wire [7:3]  paOut,
  output wire        paOeN7,
  output wire        paOeN3,
  // Port B pins
  output reg  [7:0]  pbOut_r,
  // Port C pins
  input  wire [7:0]  pcIn,
  output reg  [7:0]  pcOut_r,
  output reg  [7:0]  pcOeN_r,
  // Expansion bus
  input  wire [15:0] busAddr,
  input  wire [7:0]  busWrData,
  input  wire        busAddrPhase,
  input  wire        busWrPhase,
  output reg  [7:0]  busRdData_r,
  output reg         pcExtAccess_r
);

  // ----------------------------------------
  // Mode strap capture
  // ----------------------------------------
  // Straps are caught on the first edge after release, never by the reset itself
  reg  [1:0] mode_r;
  reg        modeTaken_r;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_r      <= `PPABC_MODE_SINGLE;
      modeTaken_r <= `PPABC_RST_BIT;
    end else begin
      if (!modeTaken_r) begin
        mode_r      <= modeSel;
        modeTaken_r <= `PPABC_BIT_ON;
      end
    end
  end

  wire singleMode = (mode_r == `PPABC_MODE_SINGLE) ||
                    (mode_r == `PPABC_MODE_BOOT);
  wire busMode    = ~singleMode;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire hitA   = (regAddr == `PPABC_OFF_PA_DATA);
  wire hitB   = (regAddr == `PPABC_OFF_PB_DATA);
  wire hitC   = (regAddr == `PPABC_OFF_PC_DATA);
  wire hitDir = (regAddr == `PPABC_OFF_DIRC);
  wire hitCtl = (regAddr == `PPABC_OFF_PCTL);

  wire wrA    = regWr & hitA;
  wire wrB    = regWr & hitB;
  // In bus modes the port C address belongs to external memory
  wire wrC    = regWr & hitC & singleMode;
  wire wrDir  = regWr & hitDir;
  wire wrCtl  = regWr & hitCtl;

  // ----------------------------------------
  // Pulse count control register
  // ----------------------------------------
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pulseCountControl_r <= `PPABC_RST_BYTE;
    end else begin
      if (wrCtl) begin
        pulseCountControl_r <= regWrData;
      end
    end
  end

  wire pa7Direction = pulseCountControl_r[`PPABC_PCTL_DIR7];
  wire pa3Direction = pulseCountControl_r[`PPABC_PCTL_DIR3];
  wire pa3CmpSel    = pulseCountControl_r[`PPABC_PCTL_CMP3];

  // ----------------------------------------
  // Port A
  // ----------------------------------------
  wire [7:0] paRead;

  ppabc_port_a ppabc_port_a_i (
    .clk         (clk),
    .reset       (reset),
    .wrData      (regWrData),
    .wrEn        (wrA),
    .dir7        (pa7Direction),                                            
    .dir3        (pa3Direction),
    .cmpOn3      (pa3CmpSel),
    .cmpCtl      (cmpCtl),
    .cmpVal      (cmpVal),
    .paIn        (paIn),
    .paOut_r     (paOut),
    .paOeN7_r    (paOeN7),
    .paOeN3_r    (paOeN3),
    .pulseIn_r   (pulseCountInput),
    .captureIn_r (captureIn),
    .readVal     (paRead)
  );

  // ----------------------------------------
  // Port B
  // ----------------------------------------
  reg [7:0] pbLatch_r;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pbLatch_r <= `PPABC_RST_BYTE;
      pbOut_r   <= `PPABC_RST_BYTE;
    end else begin
      if (wrB) begin
        pbLatch_r <= regWrData;
      end
      if (singleMode) begin
        pbOut_r <= pbLatch_r;
      end else begin
        pbOut_r <= busAddr[15:8];
      end
    end
  end

  // ----------------------------------------
  // Port C
  // ----------------------------------------
  wire [7:0] pcGpioOut;
  wire [7:0] pcGpioOeN;
  wire [7:0] pcRead;
  wire [7:0] portcDirectionBits;

  ppabc_port_c ppabc_port_c_i (
    .clk     (clk),
    .reset   (reset),
    .wrData  (regWrData),
    .dataWr  (wrC),
    .dirWr   (wrDir),
    .pcIn    (pcIn),
    .gpioOut (pcGpioOut),
    .gpioOeN (pcGpioOeN),
    .readVal (pcRead),
    .dirBits (portcDirectionBits)
  );

  // Bus phases: low address first, then write data; read phase floats the pins
  wire       busDrives = busAddrPhase | busWrPhase;
  wire [7:0] busByte   = busAddrPhase ? busAddr[7:0] : busWrData;

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pcOut_r       <= `PPABC_RST_BYTE;
      pcOeN_r       <= `PPABC_RST_HIZ;
      busRdData_r   <= `PPABC_RST_BYTE;
      pcExtAccess_r <= `PPABC_RST_BIT;
    end else begin
      if (singleMode) begin
        pcOut_r <= pcGpioOut;
        pcOeN_r <= pcGpioOeN;
      end else begin
        pcOut_r <= busByte;
        pcOeN_r <= busDrives ? `PPABC_RST_BYTE : `PPABC_RST_HIZ;
      end
      busRdData_r   <= pcIn;
      pcExtAccess_r <= (regWr | regRd) & hitC & busMode;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Unmapped and externally owned addresses read as zero
  reg [7:0] rdNxt;

  always @* begin
    rdNxt = `PPABC_RST_BYTE;
    if (hitA) begin
      rdNxt = paRead;
    end else if (hitB) begin
      rdNxt = singleMode ? pbLatch_r : pbOut_r;
    end else if (hitC) begin
      rdNxt = singleMode ? pcRead : `PPABC_RST_BYTE;
    end else if (hitDir) begin
      rdNxt = portcDirectionBits;
    end else if (hitCtl) begin
      rdNxt = pulseCountControl_r;
    end
  end

  // Data stand for exactly the cycle after the strobe
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      regRdData_r <= `PPABC_RST_BYTE;
    end else begin
      regRdData_r <= regRd ? rdNxt : `PPABC_RST_BYTE;
    end
  end

endmodule // ppabc_top
